/* File: src/cascaded_timer_12bit_pwm.v */
`timescale 1ns/10ps
`default_nettype none
`include "pwm12_defines.vh"

module cascaded_timer_12bit_pwm
(
	input  wire       clock,              // 40 MHz system clock
	input  wire       rst,                // synchronous reset, active high
	input  wire [7:0] addr,               // register address
	input  wire [7:0] wdata,              // register write data
	input  wire       wr,                 // write strobe
	input  wire       rd,                 // read strobe
	input  wire       external_count_pin, // external count clock
	output reg  [7:0] rdata,              // read data, cycle after rd
	output reg        pulse_output_pin,   // pwm output
	output reg        overflow_irq,       // pulse on every overflow
	output reg        frame_irq           // pulse on every sixteenth overflow
);

	// software registers
	reg  [7:0]  pwm_setting_low;
	reg  [3:0]  spare_high;
	reg  [11:0] combined_pwm_setting;
	reg  [11:0] setting_buffer;
	reg         buffer_pending;
	reg  [7:0]  upper_timer_mode_reg;
	reg  [7:0]  timer_pair_control;

	// timing state
	reg  [7:0]  count;
	reg  [3:0]  frame;
	reg         flipped;

	wire        tick;
	wire        add_pulse;
	wire [1:0]  mode_field;
	wire        clock_source_select;
	wire [2:0]  clock_divider_select;
	wire        output_polarity;
	wire        buffer_enable;
	wire        cascade_select;
	wire        lower_run_bit;
	wire        upper_run_bit;
	wire        pwm_mode;
	wire        running;
	wire [3:0]  duty_high_nibble;
	wire [3:0]  duty_low_nibble;
	wire [7:0]  duty_width;
	wire [3:0]  extra_bits;
	wire [8:0]  match_target;
	wire        overflow;
	wire        frame_end;
	wire        commit;
	wire [11:0] new_setting;
	wire [11:0] shown_setting;
	reg  [7:0]  next_rdata;
	reg  [7:0]  next_count;
	reg  [3:0]  next_frame;
	reg         next_flipped;
	reg         next_pin;
	reg  [11:0] next_active;
	reg         next_pending;
	wire        match_now;
	wire [7:0]  shown_low;
	wire [7:0]  shown_high;
	wire [7:0]  status_byte;
	wire        write_low;
	wire        write_mode;
	wire        write_control;
	wire        mode_locked;

	// reset image of the two setting registers, high byte first
	localparam [15:0] reset_setting = {`RST_SETTING_HIGH, `RST_SETTING_LOW};

	assign mode_field = upper_timer_mode_reg[`MODE_FIELD_MSB:`MODE_FIELD_LSB];
	assign clock_source_select = upper_timer_mode_reg[`MODE_CLK_SRC];
	assign clock_divider_select = upper_timer_mode_reg[`MODE_DIV_MSB:`MODE_DIV_LSB];
	assign output_polarity = upper_timer_mode_reg[`MODE_POLARITY];
	assign buffer_enable = upper_timer_mode_reg[`MODE_BUF_EN];
	assign cascade_select = timer_pair_control[`CTL_CASCADE];
	assign lower_run_bit = timer_pair_control[`CTL_LOWER_RUN];
	assign upper_run_bit = timer_pair_control[`CTL_UPPER_RUN];

	assign pwm_mode = cascade_select & (mode_field == `MODE_PWM12);
	assign running = pwm_mode & upper_run_bit;

	// active setting: duty in bits 11..4, extra-pulse field in 3..0
	assign duty_high_nibble = combined_pwm_setting[11:8];
	assign duty_low_nibble = combined_pwm_setting[7:4];
	assign duty_width = {duty_high_nibble, duty_low_nibble};
	assign extra_bits = combined_pwm_setting[`EXTRA_MSB:`EXTRA_LSB];

	// later toggle by one count in chosen cycles
	assign match_target = {1'b0, duty_width} + {8'h00, add_pulse};

	assign overflow = running & tick & (count == `COUNT_LAST);
	assign frame_end = overflow & (frame == `FRAME_LAST);

	assign commit = wr & (addr == `OFS_SETTING_HIGH);
	assign new_setting = {wdata[`DUTY_HIGH_MSB:`DUTY_HIGH_LSB], pwm_setting_low};
	assign shown_setting = buffer_enable ? setting_buffer : combined_pwm_setting;
	assign shown_low = shown_setting[7:0];
	assign shown_high = {spare_high, shown_setting[11:8]};
	assign status_byte = {frame, 1'b0, flipped, buffer_pending, running};
	assign match_now = ({1'b0, count} == match_target);

	// write decode
	assign write_low = wr & (addr == `OFS_SETTING_LOW);
	assign write_mode = wr & (addr == `OFS_MODE);
	assign write_control = wr & (addr == `OFS_CONTROL);
	assign mode_locked = lower_run_bit | upper_run_bit;

	clock_source u_clock_source
	(
		.clock                (clock),
		.rst                  (rst),
		.clock_source_select  (clock_source_select),
		.clock_divider_select (clock_divider_select),
		.external_count_pin   (external_count_pin),
		.tick                 (tick)
	);

	extra_pulse_select u_extra_pulse_select
	(
		.frame_index (frame),
		.extra_bits  (extra_bits),
		.add_pulse   (add_pulse)
	);

	// mode register, locked while either run bit is set
	always @(posedge clock)
	begin
		if (rst)
			upper_timer_mode_reg <= `RST_MODE;
		else if (write_mode && !mode_locked)
			upper_timer_mode_reg <= wdata;
	end

	// control register
	always @(posedge clock)
	begin
		if (rst)
			timer_pair_control <= `RST_CONTROL;
		else if (write_control)
			timer_pair_control <= wdata;
	end

	// low setting register, only staged until the high write
	always @(posedge clock)
	begin
		if (rst)
			pwm_setting_low <= reset_setting[7:0];
		else if (write_low)
			pwm_setting_low <= wdata;
	end

	// high write: spare nibble and buffer copy
	always @(posedge clock)
	begin
		if (rst)
		begin
			spare_high <= reset_setting[15:12];
			setting_buffer <= reset_setting[11:0];
		end
		else if (commit)
		begin
			spare_high <= wdata[`SPARE_MSB:`SPARE_LSB];
			setting_buffer <= new_setting;
		end
	end

	// active setting and pending buffer flag
	always @*
	begin
		next_active = combined_pwm_setting;
		next_pending = buffer_pending;
		// a buffered commit in a frame-end cycle wins and waits for the next frame end
		if (commit)
		begin
			if (!running)
			begin
				next_active = new_setting;
				next_pending = 1'b0;
			end
			else if (!buffer_enable)
			begin
				next_active = new_setting;
				next_pending = 1'b0;
			end
			else
			begin
				next_pending = 1'b1;
			end
		end
		else if (frame_end && buffer_enable && buffer_pending)
		begin
			next_active = setting_buffer;
			next_pending = 1'b0;
		end
	end

	always @(posedge clock)
	begin
		if (rst)
		begin
			combined_pwm_setting <= reset_setting[11:0];
			buffer_pending <= 1'b0;
		end
		else
		begin
			combined_pwm_setting <= next_active;
			buffer_pending <= next_pending;
		end
	end

	// next counter, frame position and output level
	always @*
	begin
		next_count = count;
		next_frame = frame;
		next_flipped = flipped;
		next_pin = pulse_output_pin;
		if (!running)
		begin
			next_count = 8'h00;
			next_frame = 4'h0;
			next_flipped = 1'b0;
			next_pin = output_polarity;
		end
		else if (overflow)
		begin
			next_count = 8'h00;
			next_frame = frame + 4'h1;
			next_flipped = 1'b0;
			next_pin = output_polarity;
		end
		else
		begin
			if (tick)
				next_count = count + 8'h01;
			// compare every cycle so a fresh equal value hits at once
			// duty 255 plus an extra pulse never matches, pin stays at polarity
			if (!flipped && match_now)
			begin
				next_flipped = 1'b1;
				next_pin = ~output_polarity;
			end
		end
	end

	// counter and frame position
	always @(posedge clock)
	begin
		if (rst)
		begin
			count <= 8'h00;
			frame <= 4'h0;
			flipped <= 1'b0;
		end
		else
		begin
			count <= next_count;
			frame <= next_frame;
			flipped <= next_flipped;
		end
	end

	// output pin, low out of reset as polarity resets to 0
	always @(posedge clock)
	begin
		if (rst)
			pulse_output_pin <= 1'b0;
		else
			pulse_output_pin <= next_pin;
	end

	// interrupt pulses, one cycle each
	always @(posedge clock)
	begin
		if (rst)
		begin
			overflow_irq <= 1'b0;
			frame_irq <= 1'b0;
		end
		else
		begin
			overflow_irq <= overflow;
			frame_irq <= frame_end;
		end
	end

	// read data
	always @*
	begin
		next_rdata = 8'h00;
		case (addr)
			`OFS_SETTING_LOW:
				next_rdata = shown_low;
			`OFS_SETTING_HIGH:
				next_rdata = shown_high;
			`OFS_MODE:
				next_rdata = upper_timer_mode_reg;
			`OFS_CONTROL:
				next_rdata = timer_pair_control;
			`OFS_COUNT:
				next_rdata = count;
			`OFS_STATUS:
				next_rdata = status_byte;
			default:
				next_rdata = 8'h00;
		endcase
	end

	always @(posedge clock)
	begin
		if (rst)
			rdata <= 8'h00;
		else if (rd)
			rdata <= next_rdata;
		else
			rdata <= 8'h00;
	end

endmodule
`default_nettype wire

/* File: src/clock_source.v */
`timescale 1ns/10ps
`default_nettype none
`include "pwm12_defines.vh"

module clock_source
(
	input  wire       clock,                // system clock
	input  wire       rst,                  // synchronous reset
	input  wire       clock_source_select,  // 1 external pin, 0 prescaler
	input  wire [2:0] clock_divider_select, // prescaler tap
	input  wire       external_count_pin,   // external count clock
	output reg        tick                  // one-cycle source clock enable
);

	reg  [10:0] pre;
	reg         ext_prev;
	reg  [10:0] mask;

	always @*
	begin
		case (clock_divider_select)
			3'h0: mask = `DIV_MASK_0;
			3'h1: mask = `DIV_MASK_1;
			3'h2: mask = `DIV_MASK_2;
			3'h3: mask = `DIV_MASK_3;
			3'h4: mask = `DIV_MASK_4;
			3'h5: mask = `DIV_MASK_5;
			3'h6: mask = `DIV_MASK_6;
			default: mask = `DIV_MASK_7;
		endcase
	end

	// external clock counts on its falling edge
	always @(posedge clock)
	begin
		if (rst)
		begin
			pre <= 11'h000;
			ext_prev <= 1'b0;
			tick <= 1'b0;
		end
		else
		begin
			pre <= pre + 11'h001;
			ext_prev <= external_count_pin;
			if (clock_source_select)
				tick <= ext_prev & ~external_count_pin;
			else
				tick <= ((pre & mask) == mask);
		end
	end

endmodule
`default_nettype wire

/* File: src/extra_pulse_select.v */
`timescale 1ns/10ps
`default_nettype none

module extra_pulse_select
(
	input  wire [3:0] frame_index, // cycle within frame, 0 means cycle 1
	input  wire [3:0] extra_bits,  // additional-pulse field
	output wire       add_pulse    // this cycle gets one extra count
);

	// cycle n = frame_index + 1
	assign add_pulse = (extra_bits[0] & (frame_index == 4'h8))
		| (extra_bits[1] & (frame_index[2:0] == 3'h4))
		| (extra_bits[2] & (frame_index[1:0] == 2'h2))
		| (extra_bits[3] & frame_index[0]);

endmodule
`default_nettype wire

/* File: src/pwm12_defines.vh */
`ifndef PWM12_DEFINES_VH
`define PWM12_DEFINES_VH

// register offsets
`define OFS_SETTING_LOW     8'h28
`define OFS_SETTING_HIGH    8'h29
`define OFS_MODE            8'h2A
`define OFS_CONTROL         8'h2B
`define OFS_COUNT           8'h2C
`define OFS_STATUS          8'h2D

// reset values
`define RST_SETTING_LOW     8'hFF
`define RST_SETTING_HIGH    8'hFF
`define RST_MODE            8'h00
`define RST_CONTROL         8'h00

// setting field positions
`define DUTY_LOW_MSB        7
`define DUTY_LOW_LSB        4
`define EXTRA_MSB           3
`define EXTRA_LSB           0
`define DUTY_HIGH_MSB       3
`define DUTY_HIGH_LSB       0
`define SPARE_MSB           7
`define SPARE_LSB           4

// mode register fields
`define MODE_FIELD_MSB      1
`define MODE_FIELD_LSB      0
`define MODE_CLK_SRC        2
`define MODE_DIV_MSB        5
`define MODE_DIV_LSB        3
`define MODE_POLARITY       6
`define MODE_BUF_EN         7
`define MODE_PWM12          2'h2

// control register fields
`define CTL_CASCADE         0
`define CTL_LOWER_RUN       1
`define CTL_UPPER_RUN       2

// prescaler masks per divider select (source = clock / (mask + 1))
`define DIV_MASK_0          11'h7FF
`define DIV_MASK_1          11'h3FF
`define DIV_MASK_2          11'h0FF
`define DIV_MASK_3          11'h03F
`define DIV_MASK_4          11'h00F
`define DIV_MASK_5          11'h003
`define DIV_MASK_6          11'h001
`define DIV_MASK_7          11'h000

// count limits
`define COUNT_LAST          8'hFF
`define FRAME_LAST          4'hF

`endif

/* File: tb/cascaded_timer_12bit_pwm_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module cascaded_timer_12bit_pwm_tb_top;
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       ext_en = 1'b0;
	wire        ext_pin;
	wire  [7:0] rdata;
	wire        pin;
	wire        ovf;
	wire        frm;
	logic [7:0] got;
	logic       pol;
	int         n_fail = 0;
	int         n_tests = 0;
	int         hi;
	int         k;
	logic [7:0] rows [6][3];
	logic [7:0] rst_vals [4] = '{8'hFF, 8'hFF, 8'h00, 8'h00};
	always #12.5 clock = !clock;
	cascaded_timer_12bit_pwm cascaded_timer_12bit_pwm_i (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .external_count_pin(ext_pin), .rdata(rdata), .pulse_output_pin(pin),
		.overflow_irq(ovf), .frame_irq(frm));
	pwm12_far_side pwm12_far_side_i (.clock(clock), .enable(ext_en), .external_count_pin(ext_pin));
	task automatic conclude;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic note(bit bad, string n, int e, int g);
		n_tests++;
		if (bad)
		begin
			n_fail++;
			$display("BAD %s exp %0d got %0d", n, e, g);
		end
	endtask
	task automatic check_reg(string n, logic [7:0] e, logic [7:0] g);
		note(g !== e, n, e, g);
	endtask
	task automatic check_pin(string n, logic e, logic g);
		note(g !== e, n, e, g);
	endtask
	task automatic check_cnt(string n, int e, int g);
		note(g != e, n, e, g);
	endtask
	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(logic [7:0] a);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 got = rdata;
	endtask
	// waits for the next irq, counting active-level cycles on the way
	task automatic wait_irq(logic frame);
		hi = 0;
		k = 0;
		do
		begin
			hi += int'(pin !== pol);
			@(posedge clock);
			#1 k++;
		end
		while ((frame ? frm : ovf) !== 1'b1 && k < 5000);
		check_cnt("irq wait", 1, int'(k < 5000));
	endtask
	task automatic period(int e);
		check_pin("overflow level", pol, pin);
		wait_irq(1'b0);
		check_cnt("active time", e, hi);
	endtask
	function automatic int add(logic [3:0] e, int c);
		return int'((e[0] && c == 9) || (e[1] && c % 8 == 5) || (e[2] && c % 4 == 3) || (e[3] && c % 2 == 0));
	endfunction
	task automatic cfg(logic [7:0] m, logic [7:0] lo, logic [7:0] hb);
		wr_reg(8'h2B, 8'h00);
		repeat (12) @(posedge clock);
		wr_reg(8'h2A, m);
		wr_reg(8'h28, lo);
		wr_reg(8'h29, hb);
		rd_reg(8'h29);
		check_reg("high setting", hb, got);
		check_pin("idle level", m[6], pin);
		pol = m[6];
		wr_reg(8'h2B, 8'h05);
	endtask
	task automatic do_reset;
		@(posedge clock);
		rst <= 1'b1;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
	endtask
	initial
	begin
		rows = '{'{8'h3A, 8'hC2, 8'h01}, '{8'h3A, 8'h51, 8'hA0}, '{8'h7A, 8'h84, 8'h03},
			'{8'h3A, 8'h08, 8'h00}, '{8'h3A, 8'h30, 8'h06}, '{8'hBA, 8'h4F, 8'h02}};
		do_reset;
		foreach (rows[r])
		begin
			cfg(rows[r][0], rows[r][1], rows[r][2]);
			wait_irq(1'b1);
			for (int c = 1; c <= 16; c++)
				period(255 - {rows[r][2][3:0], rows[r][1][7:4]} - add(rows[r][1][3:0], c));
		end
		wr_reg(8'h28, 8'h70);
		wr_reg(8'h29, 8'h01);
		rd_reg(8'h28);
		check_reg("buffered read", 8'h70, got);
		wait_irq(1'b0);
		period(255 - 8'h24 - 1);
		wait_irq(1'b1);
		period(255 - 8'h17);
		wr_reg(8'h2A, 8'h7A);
		rd_reg(8'h2A);
		check_reg("mode locked", 8'hBA, got);
		cfg(8'h3A, 8'h00, 8'h0C);
		wait_irq(1'b0);
		repeat (100) @(posedge clock);
		wr_reg(8'h28, 8'h00);
		wr_reg(8'h29, 8'h02);
		wait_irq(1'b0);
		check_cnt("missed duty", 0, hi);
		period(255 - 8'h20);
		repeat (200) @(posedge clock);
		wr_reg(8'h2B, 8'h00);
		repeat (2) @(posedge clock);
		#1 check_pin("stop level", 1'b0, pin);
		rd_reg(8'h2C);
		check_reg("count cleared", 8'h00, got);
		cfg(8'h32, 8'h00, 8'h00);
		wait_irq(1'b0);
		wait_irq(1'b0);
		check_cnt("prescaled period", 512, k);
		ext_en <= 1'b1;
		cfg(8'h3E, 8'h00, 8'h00);
		wait_irq(1'b0);
		wait_irq(1'b0);
		check_cnt("external period", 1536, k);
		do_reset;
		ext_en <= 1'b0;
		foreach (rst_vals[i])
		begin
			rd_reg(8'(8'h28 + i));
			check_reg("reset value", rst_vals[i], got);
		end
		check_pin("reset level", 1'b0, pin);
		rd_reg(8'h40);
		check_reg("unmapped", 8'h00, got);
		conclude;
	end
	initial
	begin
		repeat (90000) @(posedge clock);
		n_fail++;
		conclude;
	end
endmodule
`default_nettype wire

/* File: tb/pwm12_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module pwm12_checker
(
	input wire logic       clock, // clock
	input wire logic       rst, // reset
	input wire logic [7:0] addr, // address
	input wire logic [7:0] wdata, // write data
	input wire logic       wr, // write
	input wire logic       rd, // read
	input wire logic [7:0] rdata, // read data
	input wire logic       pulse_output_pin, // output
	input wire logic       overflow_irq, // overflow
	input wire logic       frame_irq // frame end
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic [8:0] gap;
	logic [3:0] ovfs;
	// cycles since overflow, overflows since stop
	always_ff @(posedge clock)
	begin
		gap <= rst || overflow_irq ? 9'h000 : gap + 9'(gap != 9'h1FF);
		ovfs <= rst || wr && addr == 8'h2B && !wdata[2] ? 4'h0 : ovfs + 4'(overflow_irq);
	end
	sequence s_set_read;
		wr && addr == 8'h29 ##2 rd && addr == 8'h29;
	endsequence
	sequence s_stop;
		wr && addr == 8'h2B && !wdata[2];
	endsequence
	a_read_idle: assert property (!rd |=> rdata == 8'h00)
		else $error("rdata not idle");
	a_unmapped_zero: assert property (rd && (addr < 8'h28 || addr > 8'h2D) |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_setting_readback: assert property (s_set_read |=> rdata == $past(wdata, 3))
		else $error("high setting readback");
	a_frame_with_ovf: assert property (frame_irq |-> overflow_irq)
		else $error("frame without overflow");
	a_frame_count: assert property (overflow_irq |-> frame_irq == (ovfs == 4'hF))
		else $error("frame not on sixteenth overflow");
	a_ovf_gap: assert property (overflow_irq |-> gap >= 9'h0FF)
		else $error("overflow sooner than 256 counts");
	a_irq_pulse: assert property (overflow_irq |=> !overflow_irq && !frame_irq)
		else $error("interrupt pulse too long");
	a_stop_quiet: assert property (s_stop |=> ##2 ($stable(pulse_output_pin) && !overflow_irq) [*8])
		else $error("activity after stop");
endmodule
bind cascaded_timer_12bit_pwm pwm12_checker pwm12_checker_i (.clock(clock), .rst(rst), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pulse_output_pin(pulse_output_pin),
	.overflow_irq(overflow_irq), .frame_irq(frame_irq));
`default_nettype wire

/* File: tb/pwm12_far_side.sv */
`timescale 1ns/10ps
`default_nettype none
module pwm12_far_side
(
	input  wire logic clock, // system clock
	input  wire logic enable, // run count clock
	output wire logic external_count_pin // count clock
);
	logic [1:0] div = 2'h0;
	logic       level = 1'b1;
	assign external_count_pin = level;
	// three cycles per level, still when disabled
	always @(posedge clock)
		if (enable)
		begin
			div <= div == 2'h2 ? 2'h0 : div + 2'h1;
			if (div == 2'h2)
				level <= !level;
		end
endmodule
`default_nettype wire
